// ==== core/smms_seq.sv ====
`timescale 1ns/10ps
// Purpose: operating-mode sequencer for the spread-spectrum modem
// Assumes: modem events arrive as one-cycle pulses on sys_clk
// Notes: register reads return one cycle after the strobe
module smms_seq (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic symbol_tick,
    input wire logic preamble_found,
    input wire logic header_found,
    input wire logic payload_end,
    input wire logic crc_bad,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_byte_req,
    input wire logic tx_finished,
    input wire logic cad_finished,
    input wire logic cad_hit,
    output logic [7:0] tx_byte,
    output logic spread_modem_select,
    output logic baseband_en,
    output logic tx_pll_en,
    output logic rx_pll_en,
    output logic rf_tx_en,
    output logic pa_ramp_en,
    output logic rf_rx_en,
    output logic gain_freeze,
    output logic cad_en,
    output logic [23:0] carrier_word
);
    import smms_pkg::*;

    typedef struct packed {
        smms_mode_t mode;
        logic family;
        logic [23:0] frf;
        logic [7:0] ptr;
        logic [7:0] tx_base;
        logic [7:0] rx_base;
        logic [7:0] tx_len;
        logic [9:0] win;
        logic implicit_hdr;
        logic [7:0] flags;
        smms_rx_t rx_st;
        logic [9:0] sym_cnt;
        logic [7:0] rx_wptr;
        logic [7:0] rx_count;
        logic [7:0] tx_rptr;
        logic buf_rd_pend;
        logic [7:0] rdata;
        logic [10:0] outs;
    } smms_seq_t;
    smms_seq_t st_ff, nxt_st;

    smms_buf_if bif();
    smms_buf_mem u_mem (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .bus(bif)
    );

    function automatic logic sel(input logic [7:0] a, input logic [7:0] want);
        return (a == want);
    endfunction

    function automatic logic is_rx(input smms_mode_t m);
        return (m == MODE_RX_CONT) || (m == MODE_RX_SINGLE);
    endfunction

    logic mode_wr;
    logic buf_wr;
    logic buf_rd;
    logic [7:0] clr;
    smms_mode_t req_mode;

    always_comb begin
        mode_wr = reg_wr && sel(reg_addr, ADDR_OPMODE);
        req_mode = smms_mode_t'(reg_wdata[OPM_MODE_LSB +: 3]);
        // buffer port is dead in sleep and while the wipe runs
        buf_wr = reg_wr && sel(reg_addr, ADDR_BUF_DATA) && st_ff.mode != MODE_SLEEP
            && !bif.busy;
        buf_rd = reg_rd && sel(reg_addr, ADDR_BUF_DATA) && st_ff.mode != MODE_SLEEP
            && !bif.busy;
        clr = (reg_wr && sel(reg_addr, ADDR_FLAGS)) ? reg_wdata : 8'h00;
    end

    always_comb begin
        nxt_st = st_ff;
        bif.we = 1'b0;
        bif.waddr = st_ff.rx_wptr;
        bif.wdata = rx_byte;
        bif.raddr = st_ff.ptr;
        bif.clear = 1'b0;

        // software clears first so hardware sets below win
        nxt_st.flags = st_ff.flags & ~clr;

        if (reg_wr) begin
            case (reg_addr)
                ADDR_OPMODE: begin
                    nxt_st.mode = req_mode;
                    if (st_ff.mode == MODE_SLEEP) begin
                        nxt_st.family = reg_wdata[OPM_FAMILY_BIT];
                    end
                    if (req_mode == MODE_SLEEP && st_ff.mode != MODE_SLEEP) begin
                        bif.clear = 1'b1;
                    end
                end
                ADDR_FRF_MSB: nxt_st.frf[23:16] = reg_wdata;
                ADDR_FRF_MID: nxt_st.frf[15:8] = reg_wdata;
                ADDR_FRF_LSB: nxt_st.frf[7:0] = reg_wdata;
                ADDR_PTR: nxt_st.ptr = reg_wdata;
                ADDR_TX_BASE: nxt_st.tx_base = reg_wdata;
                ADDR_RX_BASE: nxt_st.rx_base = reg_wdata;
                ADDR_TX_LEN: nxt_st.tx_len = reg_wdata;
                ADDR_CTRL: nxt_st.implicit_hdr = reg_wdata[CTRL_IMPLICIT_BIT];
                ADDR_WIN_MSB: nxt_st.win[9:8] = reg_wdata[1:0];
                ADDR_WIN_LSB: nxt_st.win[7:0] = reg_wdata;
                default: ;
            endcase
        end

        // host buffer port, pointer steps after every access
        if (buf_wr) begin
            bif.we = 1'b1;
            bif.waddr = st_ff.ptr;
            bif.wdata = reg_wdata;
            nxt_st.ptr = st_ff.ptr + 8'h01;
        end
        if (buf_rd) begin
            nxt_st.ptr = st_ff.ptr + 8'h01;
        end
        nxt_st.buf_rd_pend = buf_rd;

        // mode entry resets the receive search and timeout count
        if (mode_wr) begin
            nxt_st.rx_st = RX_SEARCH;
            nxt_st.sym_cnt = 10'h000;
            nxt_st.rx_wptr = st_ff.rx_base;
            nxt_st.rx_count = 8'h00;
            nxt_st.tx_rptr = st_ff.tx_base;
        end else begin
            case (st_ff.mode)
                MODE_TX: begin
                    if (tx_byte_req) begin
                        nxt_st.tx_rptr = st_ff.tx_rptr + 8'h01;
                    end
                    if (tx_finished) begin
                        nxt_st.flags[FLG_TX_DONE] = 1'b1;
                        nxt_st.mode = MODE_STANDBY;
                    end
                end
                MODE_RX_SINGLE, MODE_RX_CONT: begin
                    case (st_ff.rx_st)
                        RX_SEARCH: begin
                            if (preamble_found) begin
                                nxt_st.sym_cnt = 10'h000;
                                nxt_st.rx_st = st_ff.implicit_hdr ? RX_PAYLOAD
                                    : RX_HEADER;
                            end else if (symbol_tick) begin
                                // a window below the minimum acts as the minimum
                                if (st_ff.sym_cnt + 10'h001 >=
                                    ((st_ff.win < WIN_MIN) ? WIN_MIN : st_ff.win)) begin
                                    nxt_st.flags[FLG_RX_TIMEOUT] = 1'b1;
                                    nxt_st.sym_cnt = 10'h000;
                                    if (st_ff.mode == MODE_RX_SINGLE) begin
                                        nxt_st.mode = MODE_STANDBY;
                                    end
                                end else begin
                                    nxt_st.sym_cnt = st_ff.sym_cnt + 10'h001;
                                end
                            end
                        end
                        RX_HEADER: begin
                            if (header_found) begin
                                nxt_st.flags[FLG_HDR_OK] = 1'b1;
                                nxt_st.rx_st = RX_PAYLOAD;
                            end
                        end
                        RX_PAYLOAD: begin
                            if (rx_byte_valid) begin
                                bif.we = !buf_wr;
                                nxt_st.rx_wptr = st_ff.rx_wptr + 8'h01;
                                nxt_st.rx_count = st_ff.rx_count + 8'h01;
                            end
                            if (payload_end) begin
                                nxt_st.flags[FLG_RX_DONE] = 1'b1;
                                if (crc_bad) begin
                                    nxt_st.flags[FLG_CRC_ERR] = 1'b1;
                                end
                                nxt_st.rx_st = RX_SEARCH;
                                if (st_ff.mode == MODE_RX_SINGLE) begin
                                    nxt_st.mode = MODE_STANDBY;
                                end
                            end
                        end
                        default: nxt_st.rx_st = RX_SEARCH;
                    endcase
                end
                MODE_CAD: begin
                    if (cad_finished) begin
                        nxt_st.flags[FLG_CAD_DONE] = 1'b1;
                        nxt_st.flags[FLG_CAD_DET] = cad_hit | nxt_st.flags[FLG_CAD_DET];
                        nxt_st.mode = MODE_STANDBY;
                    end
                end
                default: ;
            endcase
        end

        // read data, one cycle after the strobe
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_OPMODE: nxt_st.rdata = {st_ff.family, 4'h0, st_ff.mode};
                ADDR_FRF_MSB: nxt_st.rdata = st_ff.frf[23:16];
                ADDR_FRF_MID: nxt_st.rdata = st_ff.frf[15:8];
                ADDR_FRF_LSB: nxt_st.rdata = st_ff.frf[7:0];
                ADDR_PTR: nxt_st.rdata = st_ff.ptr;
                ADDR_TX_BASE: nxt_st.rdata = st_ff.tx_base;
                ADDR_RX_BASE: nxt_st.rdata = st_ff.rx_base;
                ADDR_TX_LEN: nxt_st.rdata = st_ff.tx_len;
                ADDR_CTRL: nxt_st.rdata = {7'h00, st_ff.implicit_hdr};
                ADDR_FLAGS: nxt_st.rdata = st_ff.flags;
                ADDR_RX_COUNT: nxt_st.rdata = st_ff.rx_count;
                ADDR_WIN_MSB: nxt_st.rdata = {6'h00, st_ff.win[9:8]};
                ADDR_WIN_LSB: nxt_st.rdata = st_ff.win[7:0];
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        // resource enables follow the mode being entered
        case (nxt_st.mode)
            MODE_SLEEP: nxt_st.outs = 11'b000_0000_0000;
            MODE_STANDBY: nxt_st.outs = 11'b100_0000_0000;
            MODE_TX_SYNTH: nxt_st.outs = 11'b110_0000_0000;
            MODE_RX_SYNTH: nxt_st.outs = 11'b101_0000_0000;
            MODE_TX: nxt_st.outs = 11'b110_1100_0000;
            MODE_RX_CONT, MODE_RX_SINGLE: nxt_st.outs = 11'b101_0001_0000;
            MODE_CAD: nxt_st.outs = 11'b101_0001_1000;
            default: nxt_st.outs = 11'b000_0000_0000;
        endcase
        nxt_st.outs[5] = nxt_st.outs[4] && is_rx(nxt_st.mode)
            && nxt_st.rx_st != RX_SEARCH;
        bif.raddr = (st_ff.mode == MODE_TX) ? st_ff.tx_rptr : nxt_st.ptr;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_ff <= '{mode: MODE_SLEEP, family: 1'b0, frf: FRF_RESET, ptr: 8'h00,
                tx_base: TX_BASE_RESET, rx_base: RX_BASE_RESET, tx_len: TX_LEN_RESET,
                win: WIN_RESET, implicit_hdr: 1'b0, flags: 8'h00, rx_st: RX_SEARCH,
                sym_cnt: 10'h000, rx_wptr: 8'h00, rx_count: 8'h00, tx_rptr: 8'h00,
                buf_rd_pend: 1'b0, rdata: 8'h00, outs: 11'h000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // buffer reads come from the memory register, others from rdata
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            tx_byte <= 8'h00;
        end else begin
            reg_rdata <= nxt_st.buf_rd_pend ? bif.rdata : nxt_st.rdata;
            tx_byte <= (st_ff.mode == MODE_TX) ? bif.rdata : 8'h00;
        end
    end

    assign spread_modem_select = st_ff.family;
    assign baseband_en = st_ff.outs[10];
    assign tx_pll_en = st_ff.outs[9];
    assign rx_pll_en = st_ff.outs[8];
    assign rf_tx_en = st_ff.outs[7];
    assign pa_ramp_en = st_ff.outs[6];
    assign rf_rx_en = st_ff.outs[4];
    assign gain_freeze = st_ff.outs[5];
    assign cad_en = st_ff.outs[3];
    assign carrier_word = st_ff.frf;
endmodule

// ==== core/smms_pkg.sv ====
// Purpose: constants and types shared by the spread-modem mode sequencer
// Assumes: 10 MHz sys_clk, register port with one-cycle read latency
package smms_pkg;
    localparam logic [7:0] ADDR_BUF_DATA = 8'h00;
    localparam logic [7:0] ADDR_OPMODE = 8'h01;
    localparam logic [7:0] ADDR_FRF_MSB = 8'h06;
    localparam logic [7:0] ADDR_FRF_MID = 8'h07;
    localparam logic [7:0] ADDR_FRF_LSB = 8'h08;
    localparam logic [7:0] ADDR_PTR = 8'h0d;
    localparam logic [7:0] ADDR_TX_BASE = 8'h0e;
    localparam logic [7:0] ADDR_RX_BASE = 8'h0f;
    localparam logic [7:0] ADDR_FLAGS = 8'h12;
    localparam logic [7:0] ADDR_WIN_MSB = 8'h1e;
    localparam logic [7:0] ADDR_WIN_LSB = 8'h1f;
    localparam logic [7:0] ADDR_TX_LEN = 8'h22;
    localparam logic [7:0] ADDR_RX_COUNT = 8'h13;
    localparam logic [7:0] ADDR_CTRL = 8'h1d;

    // opmode field layout
    localparam int OPM_FAMILY_BIT = 7;
    localparam int OPM_MODE_LSB = 0;
    // flag register layout, write one to clear
    localparam int FLG_RX_TIMEOUT = 7;
    localparam int FLG_RX_DONE = 6;
    localparam int FLG_CRC_ERR = 5;
    localparam int FLG_HDR_OK = 4;
    localparam int FLG_TX_DONE = 3;
    localparam int FLG_CAD_DONE = 2;
    localparam int FLG_CAD_DET = 0;
    // ctrl register: bit 0 selects implicit header
    localparam int CTRL_IMPLICIT_BIT = 0;

    localparam logic [23:0] FRF_RESET = 24'h6c8000;
    localparam logic [9:0] WIN_RESET = 10'h005;
    localparam logic [9:0] WIN_MIN = 10'h004;
    localparam logic [7:0] TX_BASE_RESET = 8'h80;
    localparam logic [7:0] RX_BASE_RESET = 8'h00;
    localparam logic [7:0] TX_LEN_RESET = 8'h01;
    localparam int FRF_STEP_SHIFT = 19;
    localparam int BUF_DEPTH = 256;
    localparam logic [7:0] BUF_LAST = 8'hff;

    typedef enum logic [2:0] {
        MODE_SLEEP = 3'b000,
        MODE_STANDBY = 3'b001,
        MODE_TX_SYNTH = 3'b010,
        MODE_TX = 3'b011,
        MODE_RX_SYNTH = 3'b100,
        MODE_RX_CONT = 3'b101,
        MODE_RX_SINGLE = 3'b110,
        MODE_CAD = 3'b111
    } smms_mode_t;

    typedef enum logic [1:0] {
        RX_SEARCH = 2'b00,
        RX_HEADER = 2'b01,
        RX_PAYLOAD = 2'b10
    } smms_rx_t;
endpackage

// ==== core/smms_buf_if.sv ====
`timescale 1ns/10ps
// Purpose: port bundle between sequencer and packet buffer
// Assumes: single clock, read data registered in the memory
// Notes: clear wipes the whole buffer one word per cycle
interface smms_buf_if;
    logic we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;
    logic clear;
    logic busy;
    modport ctl (output we, waddr, wdata, raddr, clear, input rdata, busy);
    modport mem (input we, waddr, wdata, raddr, clear, output rdata, busy);
endinterface

// ==== core/smms_buf_mem.sv ====
`timescale 1ns/10ps
// Purpose: 256-byte packet buffer with registered read and sweep clear
// Assumes: clear is a one-cycle request
// Notes: writes during a sweep are dropped
module smms_buf_mem (
    input wire logic sys_clk,
    input wire logic rstn,
    smms_buf_if.mem bus
);
    import smms_pkg::*;
    logic [7:0] mem [0:BUF_DEPTH-1];
    typedef struct packed {
        logic busy;
        logic [7:0] idx;
        logic [7:0] rdata;
    } smms_bm_t;
    smms_bm_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = mem[bus.raddr];
        if (bus.clear) begin
            nxt_st.busy = 1'b1;
            nxt_st.idx = 8'h00;
        end else if (st_ff.busy) begin
            nxt_st.idx = st_ff.idx + 8'h01;
            if (st_ff.idx == BUF_LAST) begin
                nxt_st.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
        // sweep has priority so a cleared buffer really reads zero
        if (st_ff.busy) begin
            mem[st_ff.idx] <= 8'h00;
        end else if (bus.we) begin
            mem[bus.waddr] <= bus.wdata;
        end
    end

    assign bus.rdata = st_ff.rdata;
    assign bus.busy = st_ff.busy;
endmodule

// ==== tb/smms_seq_props.sv ====
// Purpose: concurrent checks on the mode sequencer top ports
// Assumes: single sys_clk domain, rstn synchronous active low
// Notes: mode_ff follows host mode writes only, never the automatic returns
`timescale 1ns/10ps
module smms_seq_props
    import smms_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic symbol_tick,
    input wire logic preamble_found,
    input wire logic payload_end,
    input wire logic tx_finished,
    input logic spread_modem_select,
    input logic baseband_en,
    input logic tx_pll_en,
    input logic rx_pll_en,
    input logic rf_tx_en,
    input logic pa_ramp_en,
    input logic rf_rx_en,
    input logic gain_freeze,
    input logic cad_en
);
    logic [2:0] mode_ff;
    logic op_wr;
    assign op_wr = reg_wr && reg_addr == ADDR_OPMODE;
    always_ff @(posedge sys_clk) begin
        if (!rstn) mode_ff <= 3'h0;
        else if (op_wr) mode_ff <= reg_wdata[2:0];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_sleep_all_off: assert property (op_wr && reg_wdata[2:0] == 3'h0 |=>
        !baseband_en && !tx_pll_en && !rx_pll_en && !rf_tx_en && !rf_rx_en)
        else $error("sleep left a block enabled");
    chk_standby_plls_off: assert property (op_wr && reg_wdata[2:0] == 3'h1 |=>
        baseband_en && !tx_pll_en && !rx_pll_en && !rf_tx_en && !rf_rx_en)
        else $error("standby enables wrong");
    chk_txsynth_pll_only: assert property (op_wr && reg_wdata[2:0] == 3'h2 |=>
        tx_pll_en && !rx_pll_en && !rf_tx_en && !rf_rx_en)
        else $error("tx synthesis enables wrong");
    chk_rxsynth_pll_only: assert property (op_wr && reg_wdata[2:0] == 3'h4 |=>
        rx_pll_en && !tx_pll_en && !rf_tx_en && !rf_rx_en)
        else $error("rx synthesis enables wrong");
    chk_tx_chain_on: assert property (op_wr && reg_wdata[2:0] == 3'h3 |=>
        tx_pll_en && rf_tx_en && pa_ramp_en)
        else $error("transmit chain not powered");
    chk_tx_end_standby: assert property (rf_tx_en && tx_finished && !reg_wr |=>
        !rf_tx_en && !tx_pll_en && baseband_en)
        else $error("no standby after transmit end");
    chk_cad_enable: assert property (op_wr && reg_wdata[2:0] == 3'h7 |=> cad_en)
        else $error("activity detect not enabled");
    chk_family_in_sleep: assert property (!$stable(spread_modem_select) |->
        $past(mode_ff) == 3'h0)
        else $error("family bit changed outside sleep");
    chk_cont_keeps_rx: assert property (mode_ff == 3'h5 && rf_rx_en && symbol_tick
        && !reg_wr |=> rf_rx_en)
        else $error("continuous receive dropped");
    chk_single_done_off: assert property (mode_ff == 3'h6 && rf_rx_en && payload_end
        && !reg_wr |=> !rf_rx_en && !rx_pll_en && baseband_en)
        else $error("single receive did not power down");
    chk_gain_fixed: assert property (mode_ff == 3'h6 && rf_rx_en && preamble_found
        && !reg_wr |=> gain_freeze)
        else $error("gain not fixed after preamble");
endmodule

// ==== tb/smms_modem_model.sv ====
// Purpose: behavioural modem datapath beside the sequencer
// Assumes: events are one-cycle pulses with at least two idle cycles between them
// Notes: rx_byte shows the inverse of the last byte once released
`timescale 1ns/10ps
module smms_modem_model (
    input wire logic sys_clk,
    input wire logic [7:0] tx_byte,
    output logic symbol_tick,
    output logic preamble_found,
    output logic header_found,
    output logic payload_end,
    output logic crc_bad,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic tx_byte_req,
    output logic tx_finished,
    output logic cad_finished,
    output logic cad_hit
);
    logic [7:0] txq[$];
    initial begin
        {symbol_tick, preamble_found, header_found, payload_end, crc_bad} = '0;
        {rx_byte_valid, rx_byte, tx_byte_req, tx_finished, cad_finished, cad_hit} = '0;
    end
    // 0 tick 1 preamble 2 header 3 good end 4 bad end 5 byte 6 tx request 7 tx end 8 cad hit
    task automatic ev(input int k, input logic [7:0] d);
        @(posedge sys_clk);
        case (k)
            0: symbol_tick <= 1'b1;
            1: preamble_found <= 1'b1;
            2: header_found <= 1'b1;
            3: payload_end <= 1'b1;
            4: {payload_end, crc_bad} <= 2'b11;
            5: {rx_byte_valid, rx_byte} <= {1'b1, d};
            6: tx_byte_req <= 1'b1;
            7: tx_finished <= 1'b1;
            default: {cad_finished, cad_hit} <= 2'b11;
        endcase
        @(posedge sys_clk);
        {symbol_tick, preamble_found, header_found, payload_end, crc_bad} <= '0;
        {rx_byte_valid, tx_byte_req, tx_finished, cad_finished, cad_hit} <= '0;
        rx_byte <= ~d;
        @(posedge sys_clk);
    endtask
    // byte is taken before each request, since the request moves the read pointer
    task automatic run_tx(input int n);
        txq.delete();
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge sys_clk);
            #1;
            txq.push_back(tx_byte);
            ev(6, 8'h00);
        end
        ev(7, 8'h00);
    endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the spread-modem mode sequencer
// Assumes: modem model on the far side; buffer seen via port reads and transmit
// Notes: random values from an xorshift seeded with 83
`timescale 1ns/10ps
module testbench;
    import smms_pkg::*;
    localparam int LIMIT = 20000;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, rx_byte, tx_byte, rd_val, d;
    logic symbol_tick, preamble_found, header_found, payload_end, crc_bad, rx_byte_valid;
    logic tx_byte_req, tx_finished, cad_finished, cad_hit, spread_modem_select;
    logic baseband_en, tx_pll_en, rx_pll_en, rf_tx_en, pa_ramp_en, rf_rx_en, gain_freeze;
    logic cad_en;
    logic [23:0] carrier_word, f;
    logic [6:0] en_vec;
    logic [31:0] seed = 32'h00000053;
    logic [2:0] m;
    logic [7:0] data_q[$];
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int w;
    assign en_vec = {baseband_en, tx_pll_en, rx_pll_en, rf_tx_en, pa_ramp_en, rf_rx_en, cad_en};

    smms_seq dut (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .symbol_tick, .preamble_found, .header_found, .payload_end, .crc_bad, .rx_byte_valid,
        .rx_byte, .tx_byte_req, .tx_finished, .cad_finished, .cad_hit, .tx_byte,
        .spread_modem_select, .baseband_en, .tx_pll_en, .rx_pll_en, .rf_tx_en, .pa_ramp_en,
        .rf_rx_en, .gain_freeze, .cad_en, .carrier_word);
    smms_modem_model modem (.sys_clk, .tx_byte, .symbol_tick, .preamble_found, .header_found,
        .payload_end, .crc_bad, .rx_byte_valid, .rx_byte, .tx_byte_req, .tx_finished,
        .cad_finished, .cad_hit);

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            conclude();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // {baseband, tx pll, rx pll, rf tx, pa, rf rx, activity detect}
    function automatic logic [6:0] exp_en(input logic [2:0] md);
        case (md)
            3'h1: return 7'b1000000;
            3'h2: return 7'b1100000;
            3'h3: return 7'b1101100;
            3'h4: return 7'b1010000;
            3'h5, 3'h6: return 7'b1010010;
            default: return 7'b0000000;
        endcase
    endfunction
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic set_mode(input logic [2:0] md);
        wr_reg(ADDR_OPMODE, {5'h10, md});
    endtask
    task automatic send_cmp(input int n);
        set_mode(MODE_TX);
        modem.run_tx(n);
        #1;
        check(en_vec, exp_en(MODE_STANDBY), "standby after transmit");
        check(modem.txq.size(), n, "byte count sent");
        for (int i = 0; i < n; i++) check(modem.txq[i], data_q[i], "sent byte");
        rd_reg(ADDR_FLAGS);
        check(rd_val, 8'h08, "transmit done flag");
        wr_reg(ADDR_FLAGS, 8'hff);
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(carrier_word, FRF_RESET, "carrier reset");
        rd_reg(ADDR_WIN_LSB);
        check(rd_val, WIN_RESET[7:0], "window reset");
        wr_reg(ADDR_OPMODE, 8'h80);
        set_mode(MODE_STANDBY);
        wr_reg(ADDR_OPMODE, 8'h01);
        #1;
        check(spread_modem_select, 1'b1, "family kept outside sleep");
        $display("test family done");
        for (int i = 0; i < 16; i++) begin
            m = (i < 8) ? 3'(i) : 3'(xs());
            set_mode(m);
            #1;
            if (m == MODE_CAD) check(cad_en, 1'b1, "activity enable");
            else check(en_vec, exp_en(m), "mode enables");
        end
        set_mode(MODE_STANDBY);
        f = 24'(xs());
        wr_reg(ADDR_FRF_MSB, f[23:16]);
        wr_reg(ADDR_FRF_MID, f[15:8]);
        wr_reg(ADDR_FRF_LSB, f[7:0]);
        rd_reg(ADDR_FRF_MID);
        check(rd_val, f[15:8], "carrier readback");
        check(carrier_word, f, "carrier word");
        $display("test modes done");
        repeat (260) @(posedge sys_clk);
        rd_reg(ADDR_TX_BASE);
        check(rd_val, TX_BASE_RESET, "tx base reset");
        w = 3 + int'(xs() % 6);
        wr_reg(ADDR_PTR, TX_BASE_RESET);
        wr_reg(ADDR_TX_LEN, 8'(w));
        for (int i = 0; i < w; i++) begin
            d = 8'(xs());
            data_q.push_back(d);
            wr_reg(ADDR_BUF_DATA, d);
        end
        send_cmp(w);
        set_mode(MODE_SLEEP);
        wr_reg(ADDR_PTR, TX_BASE_RESET);
        wr_reg(ADDR_BUF_DATA, 8'h5a);
        repeat (260) @(posedge sys_clk);
        set_mode(MODE_STANDBY);
        foreach (data_q[i]) data_q[i] = 8'h00;
        send_cmp(w);
        $display("test transmit done");
        w = 4 + int'(xs() % 9);
        wr_reg(ADDR_WIN_MSB, 8'h00);
        wr_reg(ADDR_WIN_LSB, 8'(w));
        set_mode(MODE_RX_SINGLE);
        repeat (w - 1) modem.ev(0, 8'h00);
        #1;
        check(rf_rx_en, 1'b1, "still in window");
        modem.ev(0, 8'h00);
        #1;
        check(en_vec, exp_en(MODE_STANDBY), "standby on timeout");
        rd_reg(ADDR_FLAGS);
        check(rd_val, 8'h80, "timeout flag");
        wr_reg(ADDR_FLAGS, 8'hff);
        set_mode(MODE_RX_CONT);
        repeat (w) modem.ev(0, 8'h00);
        #1;
        check(en_vec, exp_en(MODE_RX_CONT), "continuous kept");
        rd_reg(ADDR_FLAGS);
        check(rd_val, 8'h80, "continuous timeout flag");
        wr_reg(ADDR_FLAGS, 8'hff);
        set_mode(MODE_STANDBY);
        $display("test timeout done");
        wr_reg(ADDR_PTR, RX_BASE_RESET);
        set_mode(MODE_RX_SINGLE);
        modem.ev(1, 8'h00);
        repeat (w + 2) modem.ev(0, 8'h00);
        #1;
        check({gain_freeze, rf_rx_en}, 2'b11, "locked without timeout");
        modem.ev(2, 8'h00);
        data_q.delete();
        for (int i = 0; i < 4; i++) begin
            d = 8'(xs());
            data_q.push_back(d);
            modem.ev(5, d);
        end
        modem.ev(4, 8'h00);
        #1;
        check(en_vec, exp_en(MODE_STANDBY), "standby after packet");
        rd_reg(ADDR_FLAGS);
        check(rd_val, 8'h70, "done crc header flags");
        wr_reg(ADDR_FLAGS, 8'hff);
        wr_reg(ADDR_TX_BASE, RX_BASE_RESET);
        wr_reg(ADDR_TX_LEN, 8'h04);
        send_cmp(4);
        rd_reg(ADDR_BUF_DATA);
        check(rd_val, data_q[0], "buffer read");
        set_mode(MODE_CAD);
        modem.ev(8, 8'h00);
        rd_reg(ADDR_FLAGS);
        check(rd_val, 8'h05, "activity flags");
        $display("test receive done");
        conclude();
    end
endmodule

bind smms_seq smms_seq_props u_props (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .symbol_tick, .preamble_found, .payload_end, .tx_finished, .spread_modem_select,
    .baseband_en, .tx_pll_en, .rx_pll_en, .rf_tx_en, .pa_ramp_en, .rf_rx_en, .gain_freeze,
    .cad_en);
